// ---- inc/sensor_i2c_pkg.sv ----
// Shared constants and types for the sensor two-wire target interface
package sensor_i2c_pkg;
	// Fixed bus address, not configurable
	localparam logic [6:0] target_addr = 7'h40;
	// Direction bit values in the header
	localparam logic dir_read = 1'b1;
	localparam logic dir_write = 1'b0;
	// Bits per byte on the bus
	localparam logic [3:0] byte_bits = 4'h8;
	localparam logic [3:0] bit_zero = 4'h0;
	// Power-up time before idle, in microseconds
	localparam int startup_us = 15000;
	// Core clock rate in MHz
	localparam int mclk_mhz = 40;
	// Startup cycles, an exact product of the two with no rounding
	localparam int startup_cycles = startup_us * mclk_mhz;
	// Transfer phases seen on the link
	typedef enum logic [4:0] {
		ph_idle = 5'b00001,
		ph_header = 5'b00010,
		ph_ack = 5'b00100,
		ph_data = 5'b01000,
		ph_ignore = 5'b10000
	} phase_t;
endpackage

// ---- hw/sync2.sv ----
// Two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
	parameter int width = 1,
	parameter logic [width-1:0] init = '0
) (
	// Destination clock and reset
	input wire logic clk,
	input wire logic rst,
	// Level in and out
	input wire logic [width-1:0] d,
	output logic [width-1:0] q
);
	logic [width-1:0] meta_reg;

	// First stage feeds only the second stage
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_reg <= init;
			q <= init;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// ---- hw/startup_timer.sv ----
// Power-up delay counter that gates readiness
`timescale 1ns/1ps
`default_nettype none
module startup_timer #(
	parameter int cycles = 600000
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Ready once the delay has run out
	output logic ready
);
	logic [31:0] count_reg;

	// Count up from reset; no later event restarts it
	always_ff @(posedge clk) begin
		if (rst) begin
			count_reg <= 32'h0;
			ready <= 1'b0;
		end else if (count_reg >= 32'(cycles - 1)) begin
			ready <= 1'b1;
		end else begin
			count_reg <= count_reg + 32'h1;
		end
	end
endmodule
`default_nettype wire

// ---- hw/sensor_i2c_target.sv ----
// Two-wire bus target front end of the sensor
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Works down to a stopped serial clock
// - Sample data on rising clock edge
// - Change output data after clock falls
// - Wait 15 ms after power-up
// - Idle automatically when not busy
// - Start makes the bus busy
// - Stop makes the bus free
// - One fixed, unconfigurable address
// - Header is address plus direction bit
// - Acknowledge byte after eighth falling edge
module sensor_i2c_target #(
	parameter int startup_cycles = sensor_i2c_pkg::startup_cycles
) (
	// Core clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Serial clock from master, clocks the link logic
	input wire logic scl_clk,
	// Serial data pin as three signals
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	// Byte for the master, byte received from master, one-cycle strobe per new byte
	input wire logic [7:0] tx_byte,
	output logic [7:0] rx_byte,
	output logic rx_valid,
	// Status toward the rest of the sensor
	output logic bus_busy,
	output logic addressed,
	output logic read_mode,
	output logic ready,
	output logic sleep
);
	////////////////////////////////////////////////////////////////
	// Core-domain view of the pins
	logic scl_s;
	logic sda_s;
	logic scl_d_reg;
	logic sda_d_reg;
	logic start_det;
	logic stop_det;
	logic busy_reg;
	logic ready_w;

	// Clock and data pins synchronised for the core-domain detectors; the link engine samples sda_in directly
	sync2 #(.width(2), .init(2'b11)) u_pin_sync (
		.clk(mclk),
		.rst(rst),
		.d({scl_clk, sda_in}),
		.q({scl_s, sda_s})
	);

	startup_timer #(.cycles(startup_cycles)) u_startup (
		.clk(mclk),
		.rst(rst),
		.ready(ready_w)
	);

	// Previous synchronised levels for edge detection
	always_ff @(posedge mclk) begin
		if (rst) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end

	// Start and stop: data moves while clock stays high
	assign start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
	assign stop_det = scl_s && scl_d_reg && !sda_d_reg && sda_s;

	// Busy from start until stop; ignored before startup ends
	always_ff @(posedge mclk) begin
		if (rst) begin
			busy_reg <= 1'b0;
		end else if (!ready_w) begin
			busy_reg <= 1'b0;
		end else if (start_det) begin
			busy_reg <= 1'b1;
		end else if (stop_det) begin
			busy_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// Link-domain byte engine on the serial clock itself.
	// Being edge driven it has no minimum rate; a stopped clock
	// simply freezes it.
	logic frame_tog_reg;
	logic frame_tog_l;
	logic frame_seen_reg;
	logic new_frame;
	logic busy_l;
	logic ready_l;
	sensor_i2c_pkg::phase_t phase_reg;
	sensor_i2c_pkg::phase_t after_ack_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	logic [7:0] tx_shift_reg;
	logic is_read_reg;
	logic hit_reg;
	logic drive_low_reg;
	logic [7:0] byte_l_reg;
	logic byte_tog_reg;

	// A start toggles this so the link sees each new frame
	always_ff @(posedge mclk) begin
		if (rst) begin
			frame_tog_reg <= 1'b0;
		end else if (start_det && ready_w) begin
			frame_tog_reg <= ~frame_tog_reg;
		end
	end

	// Half-period crossing into the link domain: taken on the falling
	// edge, first read on the next rising edge, so a whole clock-low
	// phase lets it settle. A start moves these while the clock is high,
	// so the first header bit already sees the new frame; a two-stage
	// chain on the rising edge would lose the first two header bits.
	always_ff @(negedge scl_clk) begin
		if (rst) begin
			frame_tog_l <= 1'b0;
			busy_l <= 1'b0;
			ready_l <= 1'b0;
		end else begin
			frame_tog_l <= frame_tog_reg;
			busy_l <= busy_reg;
			ready_l <= ready_w;
		end
	end

	assign new_frame = frame_tog_l != frame_seen_reg;

	// Rising edge: sample data while clock high.
	always_ff @(posedge scl_clk) begin
		if (rst || !busy_l || !ready_l) begin
			phase_reg <= sensor_i2c_pkg::ph_idle;
			bit_cnt_reg <= sensor_i2c_pkg::bit_zero;
			frame_seen_reg <= frame_tog_l;
			is_read_reg <= 1'b0;
			hit_reg <= 1'b0;
			byte_tog_reg <= 1'b0;
			byte_l_reg <= 8'h00;
			shift_reg <= 8'h00;
			after_ack_reg <= sensor_i2c_pkg::ph_idle;
		end else if (new_frame) begin
			// First rising edge after a start or repeated start
			frame_seen_reg <= frame_tog_l;
			phase_reg <= sensor_i2c_pkg::ph_header;
			shift_reg <= {7'h00, sda_in};
			bit_cnt_reg <= 4'h1;
			hit_reg <= 1'b0;
		end else begin
			unique case (phase_reg)
				sensor_i2c_pkg::ph_idle,
				sensor_i2c_pkg::ph_ignore: begin
				end
				sensor_i2c_pkg::ph_header,
				sensor_i2c_pkg::ph_data: begin
					if (!(is_read_reg && phase_reg == sensor_i2c_pkg::ph_data)) begin
						shift_reg <= {shift_reg[6:0], sda_in};
					end
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
					if (bit_cnt_reg == sensor_i2c_pkg::byte_bits - 4'h1) begin
						phase_reg <= sensor_i2c_pkg::ph_ack;
						// Remember which byte this acknowledge closes
						after_ack_reg <= phase_reg;
						if (phase_reg == sensor_i2c_pkg::ph_header) begin
							// Only the fixed address is answered
							hit_reg <= shift_reg[6:0] == sensor_i2c_pkg::target_addr;
							is_read_reg <= sda_in == sensor_i2c_pkg::dir_read;
						end else if (!is_read_reg) begin
							byte_l_reg <= {shift_reg[6:0], sda_in};
							byte_tog_reg <= ~byte_tog_reg;
						end
					end
				end
				sensor_i2c_pkg::ph_ack: begin
					bit_cnt_reg <= sensor_i2c_pkg::bit_zero;
					// Master NACK on read, or no match, ends our part
					if (!hit_reg || (is_read_reg && sda_in)) begin
						phase_reg <= sensor_i2c_pkg::ph_ignore;
					end else begin
						phase_reg <= sensor_i2c_pkg::ph_data;
					end
				end
			endcase
		end
	end

	// Falling edge: update output bit, valid till next fall.
	always_ff @(negedge scl_clk) begin
		if (rst || !busy_l || !ready_l) begin
			drive_low_reg <= 1'b0;
			tx_shift_reg <= 8'hff;
		end else if (phase_reg == sensor_i2c_pkg::ph_ack && !is_read_reg) begin
			// Acknowledge after the eighth falling edge
			drive_low_reg <= hit_reg;
		end else if (phase_reg == sensor_i2c_pkg::ph_ack && hit_reg &&
				after_ack_reg == sensor_i2c_pkg::ph_header) begin
			// Header ack for a read, and first data bit load; the ack slot
			// after a read data byte belongs to the master, so we stay off
			drive_low_reg <= 1'b1;
			tx_shift_reg <= tx_byte;
		end else if (phase_reg == sensor_i2c_pkg::ph_data && is_read_reg) begin
			drive_low_reg <= !tx_shift_reg[7];
			tx_shift_reg <= {tx_shift_reg[6:0], 1'b1};
		end else begin
			drive_low_reg <= 1'b0;
		end
	end

	// Open drain: only ever pull low, else release
	assign sda_out = 1'b0;
	always_ff @(posedge mclk) begin
		if (rst) begin
			sda_oe_n <= 1'b1;
		end else begin
			sda_oe_n <= !drive_low_reg;
		end
	end

	////////////////////////////////////////////////////////////////
	// Received bytes handed back to the core by toggle
	logic tog_sync;
	logic tog_d_reg;

	sync2 #(.width(1), .init(1'b0)) u_byte_sync (
		.clk(mclk),
		.rst(rst),
		.d(byte_tog_reg),
		.q(tog_sync)
	);

	// Byte is stable long before the toggle arrives
	always_ff @(posedge mclk) begin
		if (rst) begin
			tog_d_reg <= 1'b0;
			rx_valid <= 1'b0;
			rx_byte <= 8'h00;
		end else begin
			tog_d_reg <= tog_sync;
			rx_valid <= tog_sync != tog_d_reg;
			if (tog_sync != tog_d_reg) begin
				rx_byte <= byte_l_reg;
			end
		end
	end

	// Status outputs from flops
	always_ff @(posedge mclk) begin
		if (rst) begin
			bus_busy <= 1'b0;
			ready <= 1'b0;
			sleep <= 1'b0;
			addressed <= 1'b0;
			read_mode <= 1'b0;
		end else begin
			bus_busy <= busy_reg;
			ready <= ready_w;
			sleep <= ready_w && !busy_reg;
			addressed <= busy_reg && hit_reg;
			read_mode <= busy_reg && is_read_reg;
		end
	end
endmodule
`default_nettype wire

// ---- test/sensor_i2c_target_properties.sv ----
// Port checks for the sensor two-wire target
`timescale 1ns/1ps
`default_nettype none
module sensor_i2c_target_properties #(
	parameter int startup_cycles = 20
) (
	// Clocks and reset
	input wire logic mclk,
	input wire logic rst,
	input wire logic scl_clk,
	// Data pin and user side
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe_n,
	input wire logic [7:0] tx_byte,
	input wire logic [7:0] rx_byte,
	input wire logic rx_valid,
	// Status
	input wire logic bus_busy,
	input wire logic addressed,
	input wire logic read_mode,
	input wire logic ready,
	input wire logic sleep
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	int cnt_reg;
	////////////////////////////////
	// Cycles since reset, saturating so it never wraps
	always_ff @(posedge mclk) begin
		if (rst)
			cnt_reg <= 0;
		else if (cnt_reg < startup_cycles)
			cnt_reg <= cnt_reg + 1;
	end
	////////////////////////////////
	a_oe_drives_zero: assert property (!sda_oe_n |-> !sda_out)
		else $error("data driven high");
	a_start_busy: assert property (ready && scl_clk && $past(scl_clk) && $fell(sda_in)
		|-> ##[1:5] bus_busy) else $error("start missed");
	a_stop_frees: assert property (scl_clk && $past(scl_clk) && $rose(sda_in)
		|-> ##[1:5] !bus_busy) else $error("stop missed");
	a_quiet_unready: assert property (!ready |-> sda_oe_n)
		else $error("drive before ready");
	a_ready_delay: assert property (cnt_reg < startup_cycles - 1 |-> !ready)
		else $error("ready too early");
	a_sleep_idle: assert property ((ready && !bus_busy)[*4] |-> sleep)
		else $error("no sleep when idle");
	a_hold_scl_high: assert property (scl_clk && $past(scl_clk, 5) |-> $stable(sda_oe_n))
		else $error("data moved while clock high");
	a_addr_in_frame: assert property ($rose(addressed) |-> bus_busy)
		else $error("addressed outside frame");
	a_valid_one_cycle: assert property (rx_valid |=> !rx_valid)
		else $error("byte strobe too long");
	a_busy_no_sleep: assert property (bus_busy |-> !sleep)
		else $error("sleep during transfer");
endmodule
`default_nettype wire

// ---- test/bus_master.sv ----
// Behavioural two-wire master that only pulls data low; the clock is driven both ways
`timescale 1ns/1ps
`default_nettype none
module bus_master (
	// Wire level in, clock and pull-down out
	input wire logic sda,
	output logic scl,
	output logic sda_low
);
	// Low phase long enough for the synchronised ack to land
	// Period of 2.5 us keeps the clock at the 0.4 MHz ceiling
	int lo = 1300;
	int hi = 1200;
	int hold = 0;
	// A few clock edges at power-up, data left released
	initial begin
		sda_low = 1'b0;
		scl = 1'b1;
		#37;
		repeat (4) #50 scl = !scl;
	end
	// Data changes only while the clock is low
	task bit_io(input logic b, output logic s);
		sda_low = !b;
		#(lo);
		scl = 1'b1;
		#(hi + hold);
		s = sda;
		scl = 1'b0;
	endtask
	task start();
		sda_low = 1'b0;
		#(lo);
		scl = 1'b1;
		#(hi);
		sda_low = 1'b1;
		#(hi);
		scl = 1'b0;
	endtask
	// Leaves the clock high and still between frames
	task stop();
		sda_low = 1'b1;
		#(lo);
		scl = 1'b1;
		#(hi);
		sda_low = 1'b0;
		#(hi);
	endtask
	task byte_io(input logic [7:0] w, input logic a, output logic [7:0] r, output logic ak);
		for (int i = 7; i >= 0; i--)
			bit_io(w[i], r[i]);
		bit_io(a, ak);
	endtask
endmodule
`default_nettype wire

// ---- test/tb_sensor_i2c_bus_interface.sv ----
// Self-checking bench for the sensor two-wire target
`timescale 1ns/1ps
`default_nettype none
module tb_sensor_i2c_bus_interface;
	localparam int boot = 20;
	localparam logic [7:0] hdr_w = {sensor_i2c_pkg::target_addr, sensor_i2c_pkg::dir_write};
	localparam logic [7:0] hdr_r = {sensor_i2c_pkg::target_addr, sensor_i2c_pkg::dir_read};
	logic mclk, rst, scl_clk, m_low, sda_out, sda_oe_n, rx_valid, ak;
	logic bus_busy, addressed, read_mode, ready, sleep;
	logic [7:0] tx_byte, rx_byte, r;
	logic [31:0] seed;
	wire logic sda_in;
	int fails = 0;
	int n_tests = 0;
	int cyc = 0;
	// Open drain with pull-up
	assign sda_in = (m_low || (!sda_oe_n && !sda_out)) ? 1'b0 : 1'b1;
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = !mclk;
	end
	sensor_i2c_target #(.startup_cycles(boot)) i_sensor_i2c_target (.mclk, .rst, .scl_clk,
		.sda_in, .sda_out, .sda_oe_n, .tx_byte, .rx_byte, .rx_valid, .bus_busy, .addressed,
		.read_mode, .ready, .sleep);
	bus_master i_bus_master (.sda(sda_in), .scl(scl_clk), .sda_low(m_low));
	////////////////////////////////
	function logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task check(input string nm, input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task end_of_test();
		if (fails == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Hang guard, about twice the expected run
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 40000) begin
			fails++;
			end_of_test();
		end
	end
	////////////////////////////////
	initial begin
		rst = 1'b1;
		tx_byte = 8'h00;
		seed = 32'h885e;
		repeat (20) @(negedge mclk);
		rst = 1'b0;
		check("ready", 8'(ready), 8'h00);
		repeat (boot + 4) @(negedge mclk);
		check("ready", 8'(ready), 8'h01);
		for (int k = 0; k < 4; k++) begin
			seed = lfsr(seed);
			@(negedge mclk);
			tx_byte = seed[15:8];
			check("sleep", 8'(sleep), 8'h01);
			i_bus_master.start();
			i_bus_master.byte_io(hdr_w, 1'b1, r, ak);
			check("ack", 8'(ak), 8'h00);
			check("busy", 8'(bus_busy), 8'h01);
			// Round one stretches the clock-high phases of the written data byte
			i_bus_master.hold = (k == 1) ? 3000 : 0;
			i_bus_master.byte_io(seed[7:0], 1'b1, r, ak);
			i_bus_master.hold = 0;
			check("data ack", 8'(ak), 8'h00);
			check("rx_byte", rx_byte, seed[7:0]);
			i_bus_master.start();
			i_bus_master.byte_io(hdr_r, 1'b1, r, ak);
			check("read ack", 8'(ak), 8'h00);
			check("read_mode", 8'(read_mode), 8'h01);
			i_bus_master.byte_io(8'hff, 1'b1, r, ak);
			check("read byte", r, seed[15:8]);
			i_bus_master.stop();
			repeat (8) @(negedge mclk);
			check("free", 8'(bus_busy), 8'h00);
		end
		// Any other address stays unanswered
		i_bus_master.start();
		i_bus_master.byte_io(hdr_w ^ {seed[22:17], 2'b10}, 1'b1, r, ak);
		check("foreign ack", 8'(ak), 8'h01);
		check("addressed", 8'(addressed), 8'h00);
		i_bus_master.stop();
		end_of_test();
	end
endmodule
bind sensor_i2c_target sensor_i2c_target_properties #(.startup_cycles(startup_cycles)) i_props (
	.mclk, .rst, .scl_clk, .sda_in, .sda_out, .sda_oe_n, .tx_byte, .rx_byte, .rx_valid,
	.bus_busy, .addressed, .read_mode, .ready, .sleep);
`default_nettype wire
